// >>> hdl/dps_regs.sv
// phase detector and frame sync configuration / status register bank
// assumes a synchronous byte-wide register port on the system clock
//
// Behaviour
// RULE_01 - The coarse limit code sets the tracked range to 2^(n+1)-1 UI, saturating at 8191 UI for codes 12 to 15.
// RULE_02 - With the noise window bit set, low-rate edges outside the expected 5% window are dropped from phase detection.
// RULE_03 - A read-only 16-bit two's complement averaged phase is offered over a low and a high byte from the selected loop.
// RULE_04 - The alarm delay field times twice as many seconds of pre-locked or phase-lost state before an alarm, which may expire after 128 s.
// RULE_05 - The frame pulse pin is a 50:50 wave, or with its shape bit a pulse one third-clock period wide.
// RULE_06 - The multiframe pulse pin behaves the same way under its own shape bit.
// RULE_07 - Bit 3 inverts the frame pulse pin and bit 1 inverts the multiframe pulse pin.
// RULE_08 - Bit 7 of the pulse register picks the main or auxiliary path for the low-rate general clocks.
// RULE_09 - The frame markers stay aligned to the output clocks unless independence is set, then they follow the external reference.
// RULE_10 - The fine rate bit chooses 6.48 MHz or finer sampling of the external reference and realignment of derived clocks.
// RULE_11 - The two-bit offset field moves the external sampling point on target, half UI early, one UI late or half UI late.
// RULE_12 - With the trigger bit clear, offset changes are ramped step by step instead of jumping.
// RULE_13 - Writing the trigger bit runs holdover, ramp to zero, divider reset, ramp back, leave holdover, then clears the bit.
// RULE_14 - Unused bits read as zero and ignore writes.
module dps_regs
  import dps_pkg::*;
#(
  parameter int SECOND_CYCLES = CLOCK_HZ         // cycles in one second
)(
  input  wire logic        CLOCK,             // 50 MHz system clock
  input  wire logic        RSTN,              // async reset, active low
  input  wire logic [7:0]  ADDR,              // register offset
  input  wire logic        WR_EN,             // write strobe
  input  wire logic        RD_EN,             // read strobe
  input  wire logic [7:0]  WDATA,             // write data
  output logic      [7:0]  RDATA,             // read data, next cycle
  input  wire logic [15:0] MAIN_PHASE,        // main loop averaged phase
  input  wire logic [15:0] AUX_PHASE,         // aux_dpll averaged phase
  input  wire logic        AUX_PHASE_SEL,     // 1 = read aux_dpll phase
  input  wire logic        LF_EDGE,           // low-rate input edge
  input  wire logic        LF_EDGE_IN_WINDOW, // edge inside 5% window
  output logic             EDGE_USED,         // edge passed to detector
  output logic      [12:0] TRACK_RANGE,       // coarse range in UI
  input  wire logic        PHASE_PENDING,     // pre-locked or phase-lost
  input  wire logic        ALARM_CLEAR,       // software alarm clear
  input  wire logic        ALARM_AUTO_EXPIRE, // 1 = alarm expires
  output logic             PHASE_ALARM,       // phase alarm
  input  wire logic        MAIN_8K,           // main path 8 kHz wave
  input  wire logic        MAIN_2K,           // main path 2 kHz wave
  input  wire logic        AUX_8K,            // aux path 8 kHz wave
  input  wire logic        AUX_2K,            // aux path 2 kHz wave
  input  wire logic        EXT_8K,            // ext-ref aligned 8 kHz
  input  wire logic        EXT_2K,            // ext-ref aligned 2 kHz
  input  wire logic        THIRD_CLOCK_TICK,  // third_clock_output period
  output logic             FRAME_PULSE_PIN,   // frame_pulse_pin
  output logic             MULTIFRAME_PULSE_PIN, // multiframe_pulse_pin
  output logic             GEN_8K,            // 8 kHz for general outputs
  output logic             GEN_2K,            // 2 kHz for general outputs
  output logic             FINE_SAMPLE_RATE_SELECT, // fine sampling
  output logic             REALIGN_DERIVED,   // realign derived clocks
  output logic      [1:0]  SAMPLE_OFFSET,     // sampling point shift
  input  wire logic [15:0] PROG_OFFSET,       // programmed phase offset
  output logic      [15:0] APPLIED_OFFSET,    // ramped phase offset
  output logic             HOLDOVER,          // forced holdover
  output logic             DIVIDER_RESET      // divider reset pulse
);

  localparam logic [31:0] SEC_LAST = 32'(SECOND_CYCLES - 1);

  typedef struct packed {
    logic [7:0]  coarse;
    logic [7:0]  nwin;
    logic [7:0]  alarm_dly;
    logic [7:0]  pulses;
    logic [7:0]  sampling;
    logic [7:0]  monitor;
    logic [15:0] phase;
    logic [7:0]  snap_hi;
    logic [7:0]  rdata;
    logic [12:0] range;
    logic        edge_used;
    logic [31:0] presc;
    logic [7:0]  secs;
    logic        alarm;
    logic [15:0] applied;
    logic [7:0]  step_cnt;
    dps_cal_t    cal;
    logic        holdover;
    logic        div_reset;
    logic        gen8;
    logic        gen2;
  } dps_state_t;

  dps_state_t s;
  dps_state_t next_s;
  logic       sq8;
  logic       sq2;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one ramp step of a signed offset toward a target
  function automatic logic [15:0] ramp_step(input logic [15:0] cur,
                                            input logic [15:0] tgt);
    if ($signed(cur) < $signed(tgt)) begin
      ramp_step = cur + 16'h0001;
    end else if ($signed(cur) > $signed(tgt)) begin
      ramp_step = cur - 16'h0001;
    end else begin
      ramp_step = cur;
    end
  endfunction : ramp_step

  // masked register write
  function automatic logic [7:0] wmask(input logic [7:0] d,
                                       input logic [7:0] m);
    wmask = d & m;
  endfunction : wmask

  // ----------------------------------------------------------------
  // register port, status capture and core logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.div_reset = 1'b0;
    // register writes, unused bits forced to zero [RULE_14]
    if (WR_EN) begin
      if (ADDR == OFS_COARSE) begin
        next_s.coarse = wmask(WDATA, MSK_COARSE);
      end else if (ADDR == OFS_NWIN) begin
        next_s.nwin = wmask(WDATA, MSK_NWIN);
      end else if (ADDR == OFS_ALARM) begin
        next_s.alarm_dly = wmask(WDATA, MSK_ALARM);
      end else if (ADDR == OFS_PULSES) begin
        next_s.pulses = wmask(WDATA, MSK_PULSES);
      end else if (ADDR == OFS_SAMPLING) begin
        next_s.sampling = wmask(WDATA, MSK_SAMPLING);
      end else if (ADDR == OFS_MONITOR) begin
        next_s.monitor = wmask(WDATA, MSK_MONITOR);
      end
    end
    // averaged phase from the selected loop [RULE_03]
    next_s.phase = AUX_PHASE_SEL ? AUX_PHASE : MAIN_PHASE;
    // reads; low byte read freezes the high byte for a coherent pair
    if (RD_EN) begin
      if (ADDR == OFS_COARSE) begin
        next_s.rdata = s.coarse;
      end else if (ADDR == OFS_NWIN) begin
        next_s.rdata = s.nwin;
      end else if (ADDR == OFS_PHASE_LO) begin
        next_s.rdata = s.phase[7:0]; // [RULE_03]
        next_s.snap_hi = s.phase[15:8];
      end else if (ADDR == OFS_PHASE_HI) begin
        next_s.rdata = s.snap_hi; // [RULE_03]
      end else if (ADDR == OFS_ALARM) begin
        next_s.rdata = s.alarm_dly;
      end else if (ADDR == OFS_PULSES) begin
        next_s.rdata = s.pulses;
      end else if (ADDR == OFS_SAMPLING) begin
        next_s.rdata = s.sampling;
      end else if (ADDR == OFS_MONITOR) begin
        next_s.rdata = s.monitor;
      end else begin
        next_s.rdata = 8'h00;
      end
    end
    // coarse tracking range in UI [RULE_01]
    if (s.coarse[3:0] >= COARSE_MAX_CODE) begin
      next_s.range = COARSE_MAX_UI;
    end else begin
      next_s.range = 13'((14'h0002 << s.coarse[3:0]) - 14'h0001);
    end
    // low-rate edge filter [RULE_02]
    next_s.edge_used = LF_EDGE &&
      (!s.nwin[BIT_EDGE_WINDOW] || LF_EDGE_IN_WINDOW);
    // seconds counter while pending or while an alarm stands [RULE_04]
    if (PHASE_PENDING || s.alarm) begin
      if (s.presc == SEC_LAST) begin
        next_s.presc = 32'h0000_0000;
        if (s.secs != 8'hff) begin
          next_s.secs = s.secs + 8'h01;
        end
      end else begin
        next_s.presc = s.presc + 32'h0000_0001;
      end
    end else begin
      next_s.presc = 32'h0000_0000;
      next_s.secs = 8'h00;
    end
    // alarm raise wins over clear and expiry [RULE_04]
    if (!s.alarm && PHASE_PENDING &&
        {1'b0, s.secs} >= 9'(s.alarm_dly[5:0] * ALARM_STEP_S)) begin
      next_s.alarm = 1'b1;
      next_s.presc = 32'h0000_0000;
      next_s.secs = 8'h00;
    end else if (s.alarm && (ALARM_CLEAR ||
                 (ALARM_AUTO_EXPIRE && s.secs >= ALARM_EXPIRE_S))) begin
      next_s.alarm = 1'b0;
      next_s.presc = 32'h0000_0000;
      next_s.secs = 8'h00;
    end
    // offset ramp pacing [RULE_12]
    if (s.step_cnt == RAMP_STEP_CYC - 8'h01) begin
      next_s.step_cnt = 8'h00;
    end else begin
      next_s.step_cnt = s.step_cnt + 8'h01;
    end
    // calibration sequence [RULE_13]
    case (s.cal)
      CAL_IDLE: begin
        if (s.step_cnt == 8'h00) begin
          next_s.applied = ramp_step(s.applied, PROG_OFFSET); // [RULE_12]
        end
        if (s.monitor[BIT_CAL_TRIGGER]) begin
          next_s.cal = CAL_HOLD;
        end
      end
      CAL_HOLD: begin
        next_s.holdover = 1'b1; // [RULE_13]
        next_s.cal = CAL_ZERO;
      end
      CAL_ZERO: begin
        if (s.applied == 16'h0000) begin
          next_s.div_reset = 1'b1; // [RULE_13]
          next_s.cal = CAL_DIVS;
        end else if (s.step_cnt == 8'h00) begin
          next_s.applied = ramp_step(s.applied, 16'h0000);
        end
      end
      CAL_DIVS: begin
        next_s.cal = CAL_BACK;
      end
      CAL_BACK: begin
        if (s.applied == PROG_OFFSET) begin
          next_s.holdover = 1'b0; // [RULE_13]
          next_s.monitor[BIT_CAL_TRIGGER] = 1'b0;
          next_s.cal = CAL_IDLE;
        end else if (s.step_cnt == 8'h00) begin
          next_s.applied = ramp_step(s.applied, PROG_OFFSET);
        end
      end
      default: begin
        next_s.cal = CAL_IDLE;
      end
    endcase
    // low-rate general clocks from main or aux path [RULE_08]
    next_s.gen8 = s.pulses[BIT_SRC_SELECT] ? AUX_8K : MAIN_8K;
    next_s.gen2 = s.pulses[BIT_SRC_SELECT] ? AUX_2K : MAIN_2K;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s          <= '0;
      s.coarse   <= RST_COARSE;
      s.nwin     <= RST_NWIN & MSK_NWIN;
      s.alarm_dly <= RST_ALARM;
      s.pulses   <= RST_PULSES;
      s.sampling <= RST_SAMPLING;
      s.monitor  <= RST_MONITOR;
      s.cal      <= CAL_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // frame marker sources: aligned or independent [RULE_09]
  assign sq8 = s.sampling[BIT_INDEPENDENCE] ? EXT_8K : MAIN_8K;
  assign sq2 = s.sampling[BIT_INDEPENDENCE] ? EXT_2K : MAIN_2K;

  // ----------------------------------------------------------------
  // frame and multiframe pulse shapers
  // ----------------------------------------------------------------
  dps_pulse_shaper u_frame (
    .clk         (CLOCK),
    .rstn        (RSTN),
    .square      (sq8),
    .period_tick (THIRD_CLOCK_TICK),
    .shape       (s.pulses[BIT_FRAME_SHAPE]),  // [RULE_05]
    .polarity    (s.pulses[BIT_FRAME_POL]),    // [RULE_07]
    .pin         (FRAME_PULSE_PIN)
  );

  dps_pulse_shaper u_mframe (
    .clk         (CLOCK),
    .rstn        (RSTN),
    .square      (sq2),
    .period_tick (THIRD_CLOCK_TICK),
    .shape       (s.pulses[BIT_MFRAME_SHAPE]), // [RULE_06]
    .polarity    (s.pulses[BIT_MFRAME_POL]),   // [RULE_07]
    .pin         (MULTIFRAME_PULSE_PIN)
  );

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign RDATA                   = s.rdata;
  assign EDGE_USED               = s.edge_used;
  assign TRACK_RANGE             = s.range;
  assign PHASE_ALARM             = s.alarm;
  assign GEN_8K                  = s.gen8;
  assign GEN_2K                  = s.gen2;
  assign FINE_SAMPLE_RATE_SELECT = s.sampling[BIT_FINE_RATE];  // [RULE_10]
  assign REALIGN_DERIVED         = s.sampling[BIT_FINE_RATE];  // [RULE_10]
  assign SAMPLE_OFFSET           = s.sampling[1:0];            // [RULE_11]
  assign APPLIED_OFFSET          = s.applied;
  assign HOLDOVER                = s.holdover;
  assign DIVIDER_RESET           = s.div_reset;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence seq_cal_start;
    s.cal == CAL_IDLE && s.monitor[BIT_CAL_TRIGGER];
  endsequence

  sequence seq_div_reset;
    DIVIDER_RESET && HOLDOVER && APPLIED_OFFSET == 16'h0000;
  endsequence

  a_range_saturate: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s.coarse[3:0] >= 4'hc |=> TRACK_RANGE == 13'h1fff) // [RULE_01]
    else $error("coarse range not saturated");

  a_range_code_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s.coarse[3:0] == 4'h0 |=> TRACK_RANGE == 13'h0001) // [RULE_01]
    else $error("code zero is not one UI");

  a_edge_filter_drop: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    s.nwin[7] && LF_EDGE && !LF_EDGE_IN_WINDOW |=> !EDGE_USED) // [RULE_02]
    else $error("edge outside window was used");

  a_phase_pair: assert property (@(posedge CLOCK) disable iff (!RSTN)
    RD_EN && ADDR == OFS_PHASE_LO ##[1:4] RD_EN && ADDR == OFS_PHASE_HI
      |=> RDATA == $past(s.snap_hi)) // [RULE_03]
    else $error("phase high byte not coherent");

  a_alarm_no_early: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !PHASE_ALARM && !PHASE_PENDING |=> !PHASE_ALARM) // [RULE_04]
    else $error("alarm raised without pending state");

  a_alarm_clear: assert property (@(posedge CLOCK) disable iff (!RSTN)
    PHASE_ALARM && ALARM_CLEAR |=> !PHASE_ALARM) // [RULE_04]
    else $error("alarm clear ignored");

  a_source_select: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s.pulses[7] |=> GEN_8K == $past(AUX_8K)) // [RULE_08]
    else $error("aux path not selected");

  a_unused_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !s.coarse[4] &&
    s.nwin[6:0] == 7'h00 && s.alarm_dly[7:6] == 2'h0 &&
    s.pulses[6:4] == 3'h0 && s.sampling[5:2] == 4'h0) // [RULE_14]
    else $error("unused bit holds a one");

  a_cal_enter: assert property (@(posedge CLOCK) disable iff (!RSTN)
    seq_cal_start |=> ##1 HOLDOVER) // [RULE_13]
    else $error("calibration did not enter holdover");

  a_cal_divs: assert property (@(posedge CLOCK) disable iff (!RSTN)
    seq_div_reset |=> s.cal == CAL_BACK && HOLDOVER) // [RULE_13]
    else $error("divider reset out of order");

  a_ramp_step: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s.cal == CAL_IDLE |=> APPLIED_OFFSET == $past(APPLIED_OFFSET) ||
      APPLIED_OFFSET - $past(APPLIED_OFFSET) == 16'h0001 ||
      $past(APPLIED_OFFSET) - APPLIED_OFFSET == 16'h0001) // [RULE_12]
    else $error("offset stepped instead of ramped");

endmodule : dps_regs

// >>> hdl/dps_pkg.sv
// package of offsets, reset values, field positions and timing counts
// assumes one 50 MHz system clock shared by the register port and core
package dps_pkg;

  // ----------------------------------------------------------------
  // register offsets on the configuration port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_COARSE   = 8'h74;
  localparam logic [7:0] OFS_NWIN     = 8'h76;
  localparam logic [7:0] OFS_PHASE_LO = 8'h77;
  localparam logic [7:0] OFS_PHASE_HI = 8'h78;
  localparam logic [7:0] OFS_ALARM    = 8'h79;
  localparam logic [7:0] OFS_PULSES   = 8'h7a;
  localparam logic [7:0] OFS_SAMPLING = 8'h7b;
  localparam logic [7:0] OFS_MONITOR  = 8'h7c;

  // ----------------------------------------------------------------
  // reset values and writable bit masks (clear bits read as zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_COARSE   = 8'h85;
  localparam logic [7:0] RST_NWIN     = 8'h06;
  localparam logic [7:0] RST_ALARM    = 8'h32;
  localparam logic [7:0] RST_PULSES   = 8'h00;
  localparam logic [7:0] RST_SAMPLING = 8'h00;
  localparam logic [7:0] RST_MONITOR  = 8'h2b;
  localparam logic [7:0] MSK_COARSE   = 8'hef;
  localparam logic [7:0] MSK_NWIN     = 8'h80;
  localparam logic [7:0] MSK_ALARM    = 8'h3f;
  localparam logic [7:0] MSK_PULSES   = 8'h8f;
  localparam logic [7:0] MSK_SAMPLING = 8'hc3;
  localparam logic [7:0] MSK_MONITOR  = 8'hff;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_EDGE_WINDOW   = 7;
  localparam int BIT_SRC_SELECT    = 7;
  localparam int BIT_FRAME_POL     = 3;
  localparam int BIT_FRAME_SHAPE   = 2;
  localparam int BIT_MFRAME_POL    = 1;
  localparam int BIT_MFRAME_SHAPE  = 0;
  localparam int BIT_INDEPENDENCE  = 7;
  localparam int BIT_FINE_RATE     = 6;
  localparam int BIT_CAL_TRIGGER   = 7;

  // ----------------------------------------------------------------
  // coarse range and timing
  // ----------------------------------------------------------------
  localparam logic [3:0]  COARSE_MAX_CODE = 4'hc;
  localparam logic [12:0] COARSE_MAX_UI   = 13'h1fff;
  localparam int          CLOCK_HZ        = 50_000_000;
  localparam int          ALARM_STEP_S    = 2;
  localparam logic [7:0]  ALARM_EXPIRE_S  = 8'h80;
  localparam int          RAMP_STEP_NS    = 80;
  localparam logic [7:0]  RAMP_STEP_CYC   =
    8'((RAMP_STEP_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000);

  // calibration sequence states
  typedef enum logic [4:0] {
    CAL_IDLE = 5'h01,
    CAL_HOLD = 5'h02,
    CAL_ZERO = 5'h04,
    CAL_DIVS = 5'h08,
    CAL_BACK = 5'h10
  } dps_cal_t;

endpackage : dps_pkg

// >>> hdl/dps_pulse_shaper.sv
// frame marker shaper: square wave or one-period pulse, with polarity
// assumes the square input and period tick are synchronous to clk
module dps_pulse_shaper
  import dps_pkg::*;
(
  input  wire logic clk,        // system clock
  input  wire logic rstn,       // async reset, active low
  input  wire logic square,     // 50:50 source wave
  input  wire logic period_tick,// one pulse per third clock period
  input  wire logic shape,      // 1 = pulsed output
  input  wire logic polarity,   // 1 = inverted output
  output logic      pin         // shaped marker
);

  typedef struct packed {
    logic prev;
    logic pulse;
    logic pin;
  } dps_shp_t;

  dps_shp_t s;
  dps_shp_t next_s;

  // ----------------------------------------------------------------
  // pulse starts on the rising edge, ends at the next period tick
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.prev = square;
    if (square && !s.prev) begin
      next_s.pulse = 1'b1;
    end else if (period_tick) begin
      next_s.pulse = 1'b0;
    end
    next_s.pin = (shape ? next_s.pulse : square) ^ polarity;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin = s.pin;

  a_square_follow: assert property (@(posedge clk) disable iff (!rstn)
    !shape ##1 !shape
      |-> pin == ($past(square) ^ $past(polarity))) // [RULE_05]
    else $error("square mode output does not follow source");

  a_pulse_end: assert property (@(posedge clk) disable iff (!rstn)
    shape && period_tick && !(square && !s.prev) ##1 shape
      |-> pin == $past(polarity)) // [RULE_06]
    else $error("pulse did not end at third clock period");

endmodule : dps_pulse_shaper

// >>> testbench/dps_host.sv
// host model: one register access at a time on the byte-wide port
// assumes strobes are sampled on the rising edge of CLOCK
module dps_host (
  input  wire logic       CLOCK, // system clock
  output logic      [7:0] ADDR,  // register offset
  output logic            WR_EN, // write strobe
  output logic            RD_EN, // read strobe
  output logic      [7:0] WDATA, // write data
  input  wire logic [7:0] RDATA  // read data
);
  timeunit 1ns;
  timeprecision 100ps;

  // port idles at time zero with both strobes low
  initial {ADDR, WR_EN, RD_EN, WDATA} = '0;

  // strobe held for one sampling edge, read data taken after that edge
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
    @(posedge CLOCK);
    #1;
    {ADDR, WDATA, WR_EN, RD_EN} = {a, d, w, !w};
    @(posedge CLOCK);
    #1;
    {WDATA, WR_EN, RD_EN} = {~d, 2'b00}; // released data is not kept
    q = RDATA;
  endtask : access
endmodule : dps_host

// >>> testbench/dps_regs_bench.sv
// bench for the phase and sync register bank, driven through dps_host
// assumes a 50 MHz clock and a one-second count shortened to 20 cycles
module dps_regs_bench import dps_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rstn, asel, lfe, lfw, used, pend, clr, aexp, alarm;
  logic        m8, m2, a8, a2, e8, e2, t3, fp, mp, g8, g2, fine, rel;
  logic        hold, divr, wr_en, rd_en, seen;
  logic [1:0]  soff;
  logic [7:0]  addr, wd, rdata, lo, hi;
  logic [12:0] range;
  logic [15:0] mph, aph, prog, appl;
  int          miscompares, compares, n;
  localparam logic [7:0] ofs_tab [6] = '{OFS_COARSE, OFS_NWIN, OFS_ALARM,
    OFS_PULSES, OFS_SAMPLING, OFS_MONITOR};
  localparam logic [7:0] msk_tab [6] = '{MSK_COARSE, MSK_NWIN, MSK_ALARM,
    MSK_PULSES, MSK_SAMPLING, MSK_MONITOR};
  localparam logic [7:0] rst_tab [6] = '{RST_COARSE, RST_NWIN, RST_ALARM,
    RST_PULSES, RST_SAMPLING, RST_MONITOR};

  dps_regs #(.SECOND_CYCLES(20)) i_dps_regs (
    .CLOCK(clk), .RSTN(rstn), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
    .WDATA(wd), .RDATA(rdata), .MAIN_PHASE(mph), .AUX_PHASE(aph),
    .AUX_PHASE_SEL(asel), .LF_EDGE(lfe), .LF_EDGE_IN_WINDOW(lfw),
    .EDGE_USED(used), .TRACK_RANGE(range), .PHASE_PENDING(pend),
    .ALARM_CLEAR(clr), .ALARM_AUTO_EXPIRE(aexp), .PHASE_ALARM(alarm),
    .MAIN_8K(m8), .MAIN_2K(m2), .AUX_8K(a8), .AUX_2K(a2), .EXT_8K(e8),
    .EXT_2K(e2), .THIRD_CLOCK_TICK(t3), .FRAME_PULSE_PIN(fp),
    .MULTIFRAME_PULSE_PIN(mp), .GEN_8K(g8), .GEN_2K(g2),
    .FINE_SAMPLE_RATE_SELECT(fine), .REALIGN_DERIVED(rel),
    .SAMPLE_OFFSET(soff), .PROG_OFFSET(prog), .APPLIED_OFFSET(appl),
    .HOLDOVER(hold), .DIVIDER_RESET(divr));
  dps_host i_dps_host (.CLOCK(clk), .ADDR(addr), .WR_EN(wr_en),
    .RD_EN(rd_en), .WDATA(wd), .RDATA(rdata));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #200_000;
    miscompares++;
    tally_and_finish();
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    i_dps_host.access(1'b1, a, d, q);
  endtask : wr

  task automatic rd_check(input logic [7:0] a, exp);
    logic [7:0] q;
    i_dps_host.access(1'b0, a, 8'h00, q);
    check($sformatf("register %h", a), {8'h00, exp}, {8'h00, q});
  endtask : rd_check

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, asel, lfe, lfw, pend, clr, aexp, t3, mph, aph, prog} = '0;
    {m8, m2, a8, a2, e8, e2} = 6'b100101;
    {miscompares, compares} = '0;
    tick(10);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_check(ofs_tab[i], rst_tab[i] & msk_tab[i]);
      wr(ofs_tab[i], 8'hff >> (i / 5)); // monitor gets 7f: no calibration
      rd_check(ofs_tab[i], (8'hff >> (i / 5)) & msk_tab[i]);
    end
    wr(OFS_PHASE_HI, 8'hff);
    rd_check(8'h75, 8'h00);
    {mph, aph} = {16'h8123, 16'h7e45};
    for (int s = 0; s < 2; s++) begin
      asel = s[0];
      i_dps_host.access(1'b0, OFS_PHASE_LO, 8'h00, lo);
      {mph, aph} = ~{mph, aph}; // high byte must come from the snapshot
      i_dps_host.access(1'b0, OFS_PHASE_HI, 8'h00, hi);
      check("phase", ~(s ? aph : mph), {hi, lo});
    end
    for (int c = 0; c < 16; c++) begin
      wr(OFS_COARSE, 8'(c));
      tick(2);
      n = c > 11 ? 8191 : (2 << c) - 1;
      check("range", 16'(n), 16'(range));
    end
    for (int k = 0; k < 4; k++) begin
      wr(OFS_NWIN, {k[1], 7'h00});
      {lfw, lfe, seen} = {k[0], 2'b10};
      repeat (3) begin
        tick(1);
        lfe = 1'b0;
        seen = seen | used;
      end
      check("edge used", 16'(!k[1] || k[0]), 16'(seen));
    end
    // k0 frame polarity, k1 source path, k2 independence
    for (int k = 0; k < 8; k++) begin
      wr(OFS_PULSES, {k[1], 3'h0, k[0], 1'b0, !k[0], 1'b0});
      wr(OFS_SAMPLING, {k[2], 7'h00});
      tick(3);
      check("frame pin", 16'((k[2] ? e8 : m8) ^ k[0]), 16'(fp));
      check("mframe pin", 16'((k[2] ? e2 : m2) ^ !k[0]), 16'(mp));
      n = k[1] ? {a8, a2} : {m8, m2};
      check("gen clocks", 16'(n), {14'h0, g8, g2});
    end
    {m8, m2, e8, e2} = '0;
    wr(OFS_SAMPLING, 8'h00);
    wr(OFS_PULSES, 8'h05);
    // one third clock period ends any pulse left from earlier rises
    t3 = 1'b1;
    tick(1);
    t3 = 1'b0;
    tick(3);
    check("pulse idle", 16'h0, {14'h0, fp, mp});
    {m8, m2} = 2'b11;
    tick(2);
    check("pulse start", 16'h3, {14'h0, fp, mp});
    t3 = 1'b1;
    tick(1);
    t3 = 1'b0;
    tick(2);
    check("pulse end", 16'h0, {14'h0, fp, mp});
    for (int s = 0; s < 4; s++) begin
      wr(OFS_SAMPLING, {1'b0, s[0], 4'h0, s[1:0]});
      tick(1);
      check("sample offset", 16'(s), 16'(soff));
      check("fine rate", {14'h0, s[0], s[0]}, {14'h0, fine, rel});
    end
    wr(OFS_ALARM, 8'h01);
    pend = 1'b1;
    tick(19);
    check("alarm early", 16'h0, 16'(alarm));
    tick(26);
    pend = 1'b0;
    check("alarm raised", 16'h1, 16'(alarm));
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(2);
    check("alarm cleared", 16'h0, 16'(alarm));
    // raised again, then left to expire after 128 shortened seconds
    {aexp, pend} = 2'b11;
    tick(45);
    pend = 1'b0;
    tick(2550);
    check("alarm held", 16'h1, 16'(alarm));
    tick(20);
    check("alarm expired", 16'h0, 16'(alarm));
    prog = 16'h0003;
    tick(2);
    check("stepped", 16'h0, 16'(appl === 16'h0003));
    tick(20);
    check("ramped", 16'h0003, appl);
    wr(OFS_MONITOR, 8'hab);
    for (n = 0; n < 20 && hold !== 1'b1; n++) tick(1);
    for (n = 0; n < 100 && divr !== 1'b1; n++) tick(1);
    check("hold at div reset", 16'h1, 16'(hold & divr));
    check("offset at zero", 16'h0, appl);
    for (n = 0; n < 100 && hold !== 1'b0; n++) tick(1);
    check("offset back", 16'h0003, appl);
    rd_check(OFS_MONITOR, 8'h2b);
    tally_and_finish();
  end
endmodule : dps_regs_bench
